// ===== bench/fdmc_chk_sva.sv
// Purpose: Port assertions for the divider and modulator control block
// Assumes: One clock, asynchronous active-high reset
// Notes:   Checks wait three edges so the default load after reset is not seen as a change
`timescale 1ns/1ps
module fdmc_chk
(
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic        i_wr_en,
  input wire logic        i_rd_en,
  input wire logic        i_out_silence_n,
  input wire logic [7:0]  o_rd_data,
  input wire logic        o_fb_pulse,
  input wire logic [10:0] o_feedback_divide_ratio,
  input wire logic [1:0]  o_output_power_level,
  input wire logic        o_out_mute,
  input wire logic [1:0]  o_regulator_level,
  input wire logic        o_regulator_on,
  input wire logic        o_regulator_bypass
);
  logic [1:0] up_r;
  // Edges since reset release; outputs jump to register defaults on the first one
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst || up_r != 2'h3);
  property p_bypass; o_regulator_bypass != o_regulator_on; endproperty
  a_bypass: assert property (p_bypass) else $error("bypass switch not inverse of regulator");
  property p_on_hold; !$past(i_wr_en) && !$past(i_wr_en, 2) |-> $stable(o_regulator_on); endproperty
  a_on_hold: assert property (p_on_hold) else $error("regulator state moved without a write");
  property p_lvl_hold; !$past(i_wr_en) && !$past(i_wr_en, 2) |-> $stable(o_regulator_level); endproperty
  a_lvl_hold: assert property (p_lvl_hold) else $error("regulator level moved without a write");
  property p_pwr_hold; !$past(i_wr_en) && !$past(i_wr_en, 2) |-> $stable(o_output_power_level); endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power level moved without a write");
  property p_mute_pin; !i_out_silence_n |=> o_out_mute; endproperty
  a_mute_pin: assert property (p_mute_pin) else $error("low silence pin did not mute");
  property p_rd_idle; !$past(i_rd_en) |-> o_rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
  property p_pulse_gap; o_fb_pulse |=> !o_fb_pulse [*8]; endproperty
  a_pulse_gap: assert property (p_pulse_gap) else $error("feedback pulses too close");
  property p_ratio_tc; $changed(o_feedback_divide_ratio) |-> ##[0:2] $past(o_fb_pulse); endproperty
  a_ratio_tc: assert property (p_ratio_tc) else $error("ratio changed away from terminal count");
endmodule
bind fdmc_core fdmc_chk fdmc_chk_inst (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .i_out_silence_n(i_out_silence_n), .o_rd_data(o_rd_data), .o_fb_pulse(o_fb_pulse),
  .o_feedback_divide_ratio(o_feedback_divide_ratio), .o_output_power_level(o_output_power_level),
  .o_out_mute(o_out_mute), .o_regulator_level(o_regulator_level), .o_regulator_on(o_regulator_on),
  .o_regulator_bypass(o_regulator_bypass));

// ===== bench/fdmc_core_tb.sv
// Purpose: Self-checking bench for the divider and modulator control block
// Assumes: Oscillator model toggles every second clock, so one rise per four clocks
// Notes:   Expected values come from the package limits and reset table
`timescale 1ns/1ps
module fdmc_core_tb;
  import fdmc_pkg::*;
  logic        clk, rst, we, re, sil_n, vco, fbp, oclk, mute, ron, byp, stby, unsup;
  logic [3:0]  addr;
  logic [7:0]  wd, rdat, x;
  logic [10:0] ratio, rat;
  logic [1:0]  pwr, lvl;
  int          mismatches, comparisons, cnt, sum;
  int          tn[7] = '{32, 1023, 31, 34, 35, 1019, 1020};
  fdmc_core fdmc_core_inst (.i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wr_data(wd), .i_wr_en(we),
    .i_rd_en(re), .i_vco(vco), .i_out_silence_n(sil_n), .o_rd_data(rdat), .o_fb_pulse(fbp),
    .o_feedback_divide_ratio(ratio), .o_out_clk(oclk), .o_output_power_level(pwr), .o_out_mute(mute),
    .o_regulator_level(lvl), .o_regulator_on(ron), .o_regulator_bypass(byp), .o_mod_standby(stby),
    .o_ratio_unsupported(unsup));
  fdmc_vco_model fdmc_vco_model_inst (.i_ref_clk(clk), .i_rst(rst), .o_vco(vco));
  // Reference clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task results;
    if (mismatches == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Outputs trail the registers by up to two edges
  task tick;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    tick;
  endtask
  task rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    #1 d = rdat;
  endtask
  // Write, then read the restart bit on the very next edge before it clears
  task wrrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
    @(posedge clk);
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    we <= 1'b0;
    re <= 1'b1;
    addr <= FDMC_ADDR_FLO;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdat, e);
    tick;
    rd(FDMC_ADDR_FLO, x);
    chk(x, e & 8'hfd);
  endtask
  task setn(input logic m, input logic [9:0] n);
    wr(FDMC_ADDR_MOD, {7'h00, m});
    wr(FDMC_ADDR_NHI, {6'h02, n[9:8]});
    wr(FDMC_ADDR_NLO, n[7:0]);
  endtask
  // Next divider pulse; counts oscillator rises and notes the ratio in use
  task pulse;
    logic pv;
    @(posedge clk);
    #1;
    pv = vco;
    cnt = 0;
    for (int n = 0; n < 9000 && fbp !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
      if (fbp !== 1'b1 && vco && !pv)
        cnt++;
      if (cnt == 2)
        rat = ratio;
      pv = vco;
    end
    if (fbp !== 1'b1)
      chk(fbp, 1'b1);
  endtask
  task avg8;
    pulse;
    sum = 0;
    repeat (8)
    begin
      pulse;
      sum += rat;
      chk(cnt, rat);
    end
    chk(sum, 8 * 35 + 8 * (1 << 17) / (1 << 18));
  endtask
  // Whole periods in the window, so high time is exactly half
  task odchk(input logic [2:0] od);
    int hi, tg;
    logic pv;
    wr(FDMC_ADDR_OUT, {5'h1f, od});
    repeat (40) @(posedge clk);
    #1;
    hi = 0;
    tg = 0;
    pv = oclk;
    repeat (24 * od)
    begin
      @(posedge clk);
      #1;
      hi += int'(oclk === 1'b1);
      tg += int'(oclk !== pv);
      pv = oclk;
    end
    chk({hi[7:0], tg[7:0]}, {8'(12 * od), 8'd12});
  endtask
  // Main sequence
  initial
  begin
    rst = 1'b1;
    we = 1'b0;
    re = 1'b0;
    addr = 4'h0;
    wd = 8'h00;
    sil_n = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 14; a++)
    begin
      rd(a[3:0], x);
      chk(x, (a >= 2 && a <= 11) ? FDMC_RST_VAL[a-2] & FDMC_RD_MASK[a-2] : 8'h00);
    end
    chk({lvl, pwr, ron, byp, mute}, {2'h3, 2'h3, 1'b1, 1'b0, FDMC_RST_VAL[0][FDMC_B_SIL]});
    chk(ratio, 11'd250);
    for (int l = 0; l < 4; l++)
    begin
      wr(FDMC_ADDR_REG, 8'h04 | l[7:0]);
      chk({lvl, ron, byp}, {l[1:0], 2'b10});
    end
    wr(FDMC_ADDR_REG, 8'h03);
    chk({ron, byp}, 2'b01);
    wr(FDMC_ADDR_REG, 8'h07);
    wr(FDMC_ADDR_PWR, 8'h08);
    chk({ron, byp}, 2'b01);
    wr(FDMC_ADDR_PWR, 8'h00);
    chk({ron, mute}, 2'b10);
    @(posedge clk) sil_n <= 1'b0;
    tick;
    chk(mute, 1'b1);
    @(posedge clk) sil_n <= 1'b1;
    wr(FDMC_ADDR_PWR, 8'h02);
    chk(mute, 1'b1);
    for (int p = 0; p < 4; p++)
    begin
      wr(FDMC_ADDR_OUT, {3'h7, p[1:0], 3'h1});
      chk(pwr, p[1:0]);
    end
    for (int od = 1; od < 7; od++)
      odchk(od[2:0]);
    wr(FDMC_ADDR_OUT, 8'hff);
    chk(unsup, 1'b1);
    wr(FDMC_ADDR_OUT, 8'hf9);
    wrrd(FDMC_ADDR_SEED, 8'h11, 8'hf2);
    wrrd(FDMC_ADDR_FLO, 8'hf0, 8'hf2);
    wrrd(FDMC_ADDR_REG, 8'h07, 8'hf0);
    wr(FDMC_ADDR_MOD, 8'h02);
    wrrd(FDMC_ADDR_FMID, 8'hff, 8'hf0);
    wrrd(FDMC_ADDR_FLO, 8'hf2, 8'hf2);
    setn(1'b0, 10'd35);
    wr(FDMC_ADDR_FHI, 8'h20);
    wr(FDMC_ADDR_FMID, 8'h00);
    wr(FDMC_ADDR_FLO, 8'h02);
    avg8;
    wr(FDMC_ADDR_MOD, 8'h01);
    pulse;
    pulse;
    chk({stby, rat}, {1'b1, 11'd35});
    wr(FDMC_ADDR_MOD, 8'h00);
    chk(stby, 1'b0);
    avg8;
    wr(FDMC_ADDR_FHI, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      setn(i < 3, tn[i][9:0]);
      chk(unsup, i < 3 ? tn[i] < 32 : (tn[i] < 35 || tn[i] > 1019));
      if (i < 3 && tn[i] >= 32)
      begin
        pulse;
        pulse;
        chk(cnt, tn[i]);
        chk({stby, rat}, {1'b1, tn[i][10:0]});
      end
    end
    results;
  end
  // Run takes roughly 10k clocks; this cuts a hang short
  initial
  begin
    #1_000_000;
    mismatches++;
    results;
  end
endmodule

// ===== bench/fdmc_vco_model.sv
// Purpose: Oscillator stand-in feeding the feedback and output dividers
// Assumes: Square wave locked to the reference clock
// Notes:   HALF is the half period in clocks; down to 1 the dividers still see every edge
`timescale 1ns/1ps
module fdmc_vco_model
#(
  parameter int HALF = 2
)
(
  input  wire logic i_ref_clk,
  input  wire logic i_rst,
  output logic      o_vco
);
  int cnt_r;
  // Runs freely, as an oscillator never pauses between divider cycles
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_r <= 0;
      o_vco <= 1'b0;
    end
    else if (cnt_r == HALF - 1)
    begin
      cnt_r <= 0;
      o_vco <= ~o_vco;
    end
    else
      cnt_r <= cnt_r + 1;
  end
endmodule

// ===== core/fdmc_core.sv
// Purpose: Feedback divider, delta-sigma modulator, regulator and output divider control
// Assumes: i_vco is a level synchronous to i_ref_clk, at most half its rate
// Notes:   Registers are reached by index over a plain strobe port, read data one cycle late
`timescale 1ns/1ps

module fdmc_core
(
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_rst,
  input  wire logic [3:0]             i_addr,
  input  wire logic [7:0]             i_wr_data,
  input  wire logic                   i_wr_en,
  input  wire logic                   i_rd_en,
  input  wire logic                   i_vco,
  input  wire logic                   i_out_silence_n,
  output logic      [7:0]             o_rd_data,
  output logic                        o_fb_pulse,
  output logic      [10:0]            o_feedback_divide_ratio,
  output logic                        o_out_clk,
  output logic      [1:0]             o_output_power_level,
  output logic                        o_out_mute,
  output logic      [1:0]             o_regulator_level,
  output logic                        o_regulator_on,
  output logic                        o_regulator_bypass,
  output logic                        o_mod_standby,
  output logic                        o_ratio_unsupported
);
  import fdmc_pkg::*;

  // Register map, byte wide, reached by index
  //   h02: bit 3 fractional powerdown, bit 1 output silence
  //   h03: bit 2 auto reinit on write, bit 1 dither enable, bit 0 integer mode
  //   h04: bit 2 regulator enable, bits 1:0 regulator level
  //   h05: dither seed
  //   h06: bits 1:0 feedback ratio high bits
  //   h07: feedback ratio low byte
  //   h08: bits 5:0 numerator high bits
  //   h09: numerator middle byte
  //   h0A: bits 7:4 numerator low nibble, bit 1 modulator reinit
  //   h0B: bits 4:3 output power level, bits 2:0 output ratio
  // Bits without a function are stored; reads clear only the bits that FDMC_RD_MASK leaves out,
  // so some of them, such as h0B bits 7:5, read back whatever software wrote there.
  //
  // Timing summary
  //   Read data appear one cycle after the read strobe, and only then.
  //   A write lands in the register image at the strobe edge.
  //   Analog-side controls follow the image one edge later.
  //   A reinit request is acted on two edges after the write that set it,
  //   and the bit reads back as zero from the third edge on.
  //
  // Limitations
  //   i_vco is treated as a synchronous level; it must stay put for at
  //   least one reference clock, or edges are lost by both dividers.
  //   The modulator is first order, so its noise shaping is modest; the
  //   average ratio is still exact over a full accumulator cycle while dither is off.

  typedef struct packed {
    logic [FDMC_NREG-1:0][7:0] regs;
    logic [7:0]                rd_data;
    fdmc_mod_st_t              mod_st;
    logic                      vco_prev;
    logic [10:0]               fb_cnt;
    logic [10:0]               fb_ratio;
    logic                      fb_pulse;
    logic [FDMC_NUM_W-1:0]     acc;
    logic [7:0]                lfsr;
    logic [2:0]                od_cnt;
    logic                      out_clk;
    logic [1:0]                pwr_lvl;
    logic                      mute;
    logic [1:0]                reg_lvl;
    logic                      reg_on;
    logic                      bypass;
    logic                      standby;
    logic                      unsup;
  } fdmc_state_t;

  fdmc_state_t st_r;
  fdmc_state_t st_nxt;

  // Decoded fields of the current register image
  logic [3:0]            idx;
  logic                  addr_ok;
  logic [9:0]            n_int;
  logic [FDMC_NUM_W-1:0] num;
  logic                  int_mode;
  logic                  dith_en;
  logic                  auto_re;
  logic                  reinit;
  logic [2:0]            od_code;
  logic [2:0]            od_eff;
  logic                  vco_rise;
  logic                  vco_edge;
  logic [FDMC_NUM_W:0]   acc_sum;
  logic                  dith_bit;
  logic                  lfsr_fb;
  logic                  auto_hit;
  logic                  re_keep;

  // Field extraction
  always_comb
  begin
    idx      = i_addr - FDMC_ADDR_FIRST;
    addr_ok  = (i_addr >= FDMC_ADDR_FIRST) && (i_addr <= FDMC_ADDR_LAST);
    n_int    = {st_r.regs[FDMC_ADDR_NHI - FDMC_ADDR_FIRST][1:0],
                st_r.regs[FDMC_ADDR_NLO - FDMC_ADDR_FIRST]};
    num      = {st_r.regs[FDMC_ADDR_FHI - FDMC_ADDR_FIRST][5:0],
                st_r.regs[FDMC_ADDR_FMID - FDMC_ADDR_FIRST],
                st_r.regs[FDMC_ADDR_FLO - FDMC_ADDR_FIRST][7:4]};
    int_mode = st_r.regs[FDMC_ADDR_MOD - FDMC_ADDR_FIRST][FDMC_B_INTM];
    dith_en  = st_r.regs[FDMC_ADDR_MOD - FDMC_ADDR_FIRST][FDMC_B_DITH];
    auto_re  = st_r.regs[FDMC_ADDR_MOD - FDMC_ADDR_FIRST][FDMC_B_AUTO];
    reinit   = st_r.regs[FDMC_ADDR_FLO - FDMC_ADDR_FIRST][FDMC_B_REINIT];
    od_code  = st_r.regs[FDMC_ADDR_OUT - FDMC_ADDR_FIRST][FDMC_B_OD_LO +: 3];
    // Code 0 would wrap the compare to 7 and divide by eight, so it runs as divide by one
    od_eff   = (od_code < FDMC_OD_MIN) ? FDMC_OD_MIN : od_code;
    vco_rise = i_vco & ~st_r.vco_prev;
    vco_edge = i_vco ^ st_r.vco_prev;
    // Writes inside the modulator window restart it when auto reinit is on
    auto_hit = auto_re && (i_addr >= FDMC_AUTO_FIRST) && (i_addr <= FDMC_AUTO_LAST) && i_wr_en && addr_ok;
  end

  // Modulator arithmetic: first-order accumulator over a 2^18 modulus
  always_comb
  begin
    lfsr_fb  = st_r.lfsr[7] ^ st_r.lfsr[5] ^ st_r.lfsr[4] ^ st_r.lfsr[3];
    dith_bit = dith_en & st_r.lfsr[0];
    // Bit 18, the carry out of the 18-bit sum, is the overflow against the fixed denominator
    acc_sum  = {1'b0, st_r.acc} + {1'b0, num} + {{FDMC_NUM_W{1'b0}}, dith_bit};
  end

  // Next-state logic
  // The modulator machine, both dividers, the static controls and the
  // register port all share one copy of the state, so the order of the
  // sections below decides which update wins inside one cycle.
  always_comb
  begin
    re_keep         = 1'b0;
    st_nxt          = st_r;
    st_nxt.rd_data  = 8'h00;
    st_nxt.fb_pulse = 1'b0;
    st_nxt.vco_prev = i_vco;

    // Modulator control; the reinit clear comes first so a write in the same cycle wins
    case (st_r.mod_st)
      FDMC_MOD_RUN:
      begin
        if (reinit)
          st_nxt.mod_st = FDMC_MOD_REINIT;
        else if (int_mode)
          st_nxt.mod_st = FDMC_MOD_STANDBY;
      end
      FDMC_MOD_STANDBY:
      begin
        // Accumulator stays intact so fractional operation resumes without delay
        if (reinit)
          st_nxt.mod_st = FDMC_MOD_REINIT;
        else if (!int_mode)
          st_nxt.mod_st = FDMC_MOD_RUN;
      end
      FDMC_MOD_REINIT:
      begin
        st_nxt.acc  = '0;
        st_nxt.lfsr = st_r.regs[FDMC_ADDR_SEED - FDMC_ADDR_FIRST];
        st_nxt.regs[FDMC_ADDR_FLO - FDMC_ADDR_FIRST][FDMC_B_REINIT] = 1'b0;
        st_nxt.mod_st = int_mode ? FDMC_MOD_STANDBY : FDMC_MOD_RUN;
      end
      default:
      begin
        st_nxt.mod_st = FDMC_MOD_RUN;
      end
    endcase

    // Feedback divider counts VCO rising edges; terminal count marks one PFD cycle
    if (vco_rise)
    begin
      if (st_r.fb_cnt >= st_r.fb_ratio - 11'h001)
      begin
        st_nxt.fb_cnt   = 11'h000;
        st_nxt.fb_pulse = 1'b1;
        if (st_r.mod_st == FDMC_MOD_RUN)
        begin
          // One modulator step per PFD cycle sets the ratio for the next one
          st_nxt.acc      = acc_sum[FDMC_NUM_W-1:0];
          st_nxt.fb_ratio = {1'b0, n_int} + {10'h000, acc_sum[FDMC_NUM_W]};
          st_nxt.lfsr     = {st_r.lfsr[6:0], lfsr_fb};
        end
        else
        begin
          st_nxt.fb_ratio = {1'b0, n_int};
        end
      end
      else
      begin
        st_nxt.fb_cnt = st_r.fb_cnt + 11'h001;
      end
    end

    // Output divider counts half periods, which keeps odd ratios at even duty
    if (vco_edge)
    begin
      if (st_r.od_cnt >= od_eff - 3'h1)
      begin
        st_nxt.od_cnt  = 3'h0;
        st_nxt.out_clk = ~st_r.out_clk;
      end
      else
      begin
        st_nxt.od_cnt = st_r.od_cnt + 3'h1;
      end
    end

    // Static controls registered toward the analog side
    st_nxt.pwr_lvl = st_r.regs[FDMC_ADDR_OUT - FDMC_ADDR_FIRST][FDMC_B_PWR_LO +: 2];
    st_nxt.mute    = st_r.regs[FDMC_ADDR_PWR - FDMC_ADDR_FIRST][FDMC_B_SIL]
                     | ~i_out_silence_n;
    st_nxt.reg_lvl = st_r.regs[FDMC_ADDR_REG - FDMC_ADDR_FIRST][FDMC_B_LVL_LO +: 2];
    st_nxt.reg_on  = st_r.regs[FDMC_ADDR_REG - FDMC_ADDR_FIRST][FDMC_B_REG_EN]
                     & ~st_r.regs[FDMC_ADDR_PWR - FDMC_ADDR_FIRST][FDMC_B_PD_FRAC];
    // Bypass has its own flop so the pin never sees an inverter glitch
    st_nxt.bypass  = ~st_nxt.reg_on;
    st_nxt.standby = (st_r.mod_st == FDMC_MOD_STANDBY);

    // Range check only flags; the dividers still run on whatever code is loaded, output code 0 running as 1
    if (int_mode)
      st_nxt.unsup = (n_int < FDMC_INT_N_MIN);
    else
      st_nxt.unsup = (n_int < FDMC_FRAC_N_MIN) || (n_int > FDMC_FRAC_N_MAX);
    if ((od_code < FDMC_OD_MIN) || (od_code > FDMC_OD_MAX))
      st_nxt.unsup = 1'b1;

    // Register port: read data in the next cycle, unmapped indexes read zero
    if (i_rd_en && addr_ok)
      st_nxt.rd_data = st_r.regs[idx] & FDMC_RD_MASK[idx];
    if (i_wr_en && addr_ok)
    begin
      // Value after any hardware clear; a pending restart survives the write
      re_keep          = st_nxt.regs[FDMC_ADDR_FLO - FDMC_ADDR_FIRST][FDMC_B_REINIT];
      st_nxt.regs[idx] = i_wr_data;
      // A set in the clearing cycle wins and queues one more restart
      st_nxt.regs[FDMC_ADDR_FLO - FDMC_ADDR_FIRST][FDMC_B_REINIT] =
        re_keep | ((i_addr == FDMC_ADDR_FLO) & i_wr_data[FDMC_B_REINIT]) | auto_hit;
    end
  end

  // State register; reset loads constants only
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_r          <= '0;
      st_r.regs     <= FDMC_RST_VAL;
      st_r.mod_st   <= FDMC_MOD_RUN;
      st_r.bypass   <= 1'b1;
      st_r.fb_ratio <= {1'b0, FDMC_RST_VAL[FDMC_ADDR_NHI - FDMC_ADDR_FIRST][1:0],
                        FDMC_RST_VAL[FDMC_ADDR_NLO - FDMC_ADDR_FIRST]};
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign o_rd_data               = st_r.rd_data;
  assign o_fb_pulse              = st_r.fb_pulse;
  assign o_feedback_divide_ratio = st_r.fb_ratio;
  assign o_out_clk               = st_r.out_clk;
  assign o_output_power_level    = st_r.pwr_lvl;
  assign o_out_mute              = st_r.mute;
  assign o_regulator_level       = st_r.reg_lvl;
  assign o_regulator_on          = st_r.reg_on;
  assign o_regulator_bypass      = st_r.bypass;
  assign o_mod_standby           = st_r.standby;
  assign o_ratio_unsupported     = st_r.unsup;

endmodule

// ===== core/fdmc_pkg.sv
// Purpose: Shared constants for the fractional-N divider and modulator control block
// Assumes: Byte-wide registers addressed by their printed index
// Notes:   Only registers h02 to h0B are held here; other indexes read as zero
package fdmc_pkg;

  // Register window and indexes
  localparam logic [3:0] FDMC_ADDR_FIRST = 4'h2;
  localparam logic [3:0] FDMC_ADDR_LAST  = 4'hb;
  localparam logic [3:0] FDMC_ADDR_PWR   = 4'h2;
  localparam logic [3:0] FDMC_ADDR_MOD   = 4'h3;
  localparam logic [3:0] FDMC_ADDR_REG   = 4'h4;
  localparam logic [3:0] FDMC_ADDR_SEED  = 4'h5;
  localparam logic [3:0] FDMC_ADDR_NHI   = 4'h6;
  localparam logic [3:0] FDMC_ADDR_NLO   = 4'h7;
  localparam logic [3:0] FDMC_ADDR_FHI   = 4'h8;
  localparam logic [3:0] FDMC_ADDR_FMID  = 4'h9;
  localparam logic [3:0] FDMC_ADDR_FLO   = 4'ha;
  localparam logic [3:0] FDMC_ADDR_OUT   = 4'hb;
  localparam logic [3:0] FDMC_AUTO_FIRST = 4'h5;
  localparam logic [3:0] FDMC_AUTO_LAST  = 4'ha;
  localparam int unsigned FDMC_NREG      = 10;

  // Reset values, entry 0 is index h02
  localparam logic [FDMC_NREG-1:0][7:0] FDMC_RST_VAL =
    {8'hf9, 8'hf0, 8'hff, 8'h3f, 8'hfa, 8'h08, 8'h11, 8'h07, 8'h06, 8'h06};
  // Readable bits per register; the rest read as zero
  localparam logic [FDMC_NREG-1:0][7:0] FDMC_RD_MASK =
    {8'hff, 8'hf2, 8'hff, 8'h3f, 8'hff, 8'hfb, 8'hff, 8'h0f, 8'h07, 8'hdb};

  // Bit positions
  localparam int unsigned FDMC_B_PD_FRAC  = 3;
  localparam int unsigned FDMC_B_SIL      = 1;
  localparam int unsigned FDMC_B_AUTO     = 2;
  localparam int unsigned FDMC_B_DITH     = 1;
  localparam int unsigned FDMC_B_INTM     = 0;
  localparam int unsigned FDMC_B_REG_EN   = 2;
  localparam int unsigned FDMC_B_LVL_LO   = 0;
  localparam int unsigned FDMC_B_REINIT   = 1;
  localparam int unsigned FDMC_B_OD_LO    = 0;
  localparam int unsigned FDMC_B_PWR_LO   = 3;

  // Ratio limits
  localparam logic [9:0] FDMC_FRAC_N_MIN = 10'd35;
  localparam logic [9:0] FDMC_FRAC_N_MAX = 10'd1019;
  localparam logic [9:0] FDMC_INT_N_MIN  = 10'd32;
  localparam logic [2:0] FDMC_OD_MIN     = 3'h1;
  localparam logic [2:0] FDMC_OD_MAX     = 3'h6;
  localparam int unsigned FDMC_NUM_W     = 18;

  // Modulator states, one-hot
  typedef enum logic [2:0] {
    FDMC_MOD_RUN     = 3'b001,
    FDMC_MOD_STANDBY = 3'b010,
    FDMC_MOD_REINIT  = 3'b100
  } fdmc_mod_st_t;

endpackage
